// ### include/spb_pkg.sv
// Constants, segment layout and shared helpers of the segmented local packet bus
package spb_pkg;

    localparam int SEG_NUM    = 4;
    localparam int SEG_W      = 128;
    localparam int MTY_W      = 4;
    localparam int BYTE_W     = 8;
    localparam int SEG_BYTES  = SEG_W / BYTE_W;
    localparam int FIFO_DEPTH = 16;
    localparam int LEN_W      = 16;
    localparam int MAXLEN_W   = 15;

    // Free FIFO slots at or below which transmit ready drops; overflow only occurs when no slot is free
    localparam logic [4:0]        RDY_THRESHOLD = 5'h0B;
    localparam logic [LEN_W-1:0]  MIN_FRAME_LEN = 16'h0040;
    localparam logic [4:0]        SEG_BYTES_W5  = 5'h10;
    localparam logic [2:0]        MTY_ERR_LOW   = 3'h0;
    // Error control character repeated over the whole segment
    localparam logic [SEG_W-1:0]  ERR_WORD      = {SEG_BYTES{8'hFE}};

    typedef struct packed {
        logic [SEG_W-1:0] data;
        logic             ena;
        logic             sop;
        logic             eop;
        logic             err;
        logic [MTY_W-1:0] mty;
    } spb_seg_type;

    typedef spb_seg_type [SEG_NUM-1:0] spb_word_type;

    localparam int WORD_W = $bits(spb_word_type);

    // Idle segments carry zeros; empty count only means something on an end transfer
    function automatic spb_seg_type spb_seg_clean(input spb_seg_type s);
        spb_seg_type r;
        r = s;
        if (!s.ena) begin
            r = '0;
        end else if (!s.eop) begin
            r.err = 1'b0;
            r.mty = '0;
        end
        return r;
    endfunction : spb_seg_clean

    // Segments fill from 0 upward; idle segments may only follow an end marker
    function automatic logic spb_layout_ok(input spb_word_type w);
        logic ok;
        ok = w[0].ena || (w[1].ena == 1'b0 && w[2].ena == 1'b0 && w[3].ena == 1'b0);
        for (int s = 1; s < SEG_NUM; s++) begin
            if (w[s].ena && !w[s-1].ena) begin
                ok = 1'b0;
            end
            if (w[s-1].ena && !w[s-1].eop && !w[s].ena) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : spb_layout_ok

endpackage : spb_pkg

// ### include/spb_if.sv
// Segmented packet bus joining the MAC end and the user packet logic end
`timescale 1ns/10ps
interface spb_if;
    import spb_pkg::*;

    spb_word_type tx_word;
    logic         tx_rdy;
    logic         tx_ovf;
    spb_word_type rx_word;

    modport mac (
        input  tx_word,
        output tx_rdy,
        output tx_ovf,
        output rx_word
    );

    modport user (
        output tx_word,
        input  tx_rdy,
        input  tx_ovf,
        input  rx_word
    );
endinterface : spb_if

// ### verilog/spb_mac_end.sv
// MAC end of the segmented packet bus with its transmit FIFO
`timescale 1ns/10ps
module spb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic                     sys_clk_i,
    input  wire logic                     arst_n_i,
    // Fill side
    input  wire logic                     in_valid_i,
    output logic                          in_ready_o,
    input  wire logic [WIDTH-1:0]         in_data_i,
    // Drain side
    output logic                          out_valid_o,
    input  wire logic                     out_ready_i,
    output logic [WIDTH-1:0]              out_data_o,
    // Fill level
    output logic [$clog2(DEPTH):0]        count_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    assign count_o     = wr_q - rd_q;
    assign in_ready_o  = (count_o != DEPTH[AW:0]);
    assign out_valid_o = (wr_q != rd_q);
    assign out_data_o  = mem_q[rd_q[AW-1:0]];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule : spb_fifo

module spb_mac_end
    import spb_pkg::*;
(
    // Clock and reset
    input  wire logic                  sys_clk_i,
    input  wire logic                  arst_n_i,
    // Packet bus toward user logic
    spb_if.mac                         bus,
    // Transmit words toward the line encoder
    output logic                       line_tx_valid_o,
    output spb_word_type               line_tx_word_o,
    input  wire logic                  line_tx_ready_i,
    // Decoded receive words from the line
    input  wire spb_word_type          line_rx_word_i,
    input  wire logic [SEG_NUM-1:0]    line_rx_fcs_bad_i,
    input  wire logic [SEG_NUM-1:0]    line_rx_code_bad_i,
    // Configuration
    input  wire logic [MAXLEN_W-1:0]   rx_max_frame_length_i
);
    localparam int CW = $clog2(FIFO_DEPTH) + 1;

    spb_word_type    tx_clean;
    logic            tx_write;
    logic            fifo_in_ready;
    logic [CW-1:0]   fifo_count;
    logic            tx_rdy_q;
    logic            tx_ovf_q;

    spb_word_type    rx_d;
    spb_word_type    rx_q;
    logic [LEN_W-1:0] len_d;
    logic [LEN_W-1:0] len_q;
    logic            code_bad_d;
    logic            code_bad_q;
    logic [4:0]      seg_bytes;
    logic            rx_bad;

    // Saturates so an oversized frame never wraps back into the legal range
    function automatic logic [LEN_W-1:0] len_add(input logic [LEN_W-1:0] a,
                                                 input logic [4:0]       b);
        logic [LEN_W:0] s;
        s = {1'b0, a} + {{(LEN_W-4){1'b0}}, b};
        return s[LEN_W] ? '1 : s[LEN_W-1:0];
    endfunction : len_add

    // Transmit capture: disabled segments ignored, end-of-packet fields applied
    always_comb begin
        for (int s = 0; s < SEG_NUM; s++) begin
            tx_clean[s] = spb_seg_clean(bus.tx_word[s]);
            if (tx_clean[s].eop && tx_clean[s].err) begin
                tx_clean[s].mty[2:0] = MTY_ERR_LOW;
                tx_clean[s].data     = ERR_WORD;
            end
        end
    end

    assign tx_write = bus.tx_word[0].ena || bus.tx_word[1].ena ||
                      bus.tx_word[2].ena || bus.tx_word[3].ena;

    spb_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .sys_clk_i   (sys_clk_i),
        .arst_n_i    (arst_n_i),
        .in_valid_i  (tx_write),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (tx_clean),
        .out_valid_o (line_tx_valid_o),
        .out_ready_i (line_tx_ready_i),
        .out_data_o  (line_tx_word_o),
        .count_o     (fifo_count)
    );

    // Ready drops while threshold slots remain, so the allowed writes still fit
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_rdy_q <= 1'b0;
        end else begin
            tx_rdy_q <= (FIFO_DEPTH[CW-1:0] - fifo_count) > RDY_THRESHOLD;
        end
    end

    // A write into a full FIFO is lost and flagged for one cycle
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_ovf_q <= 1'b0;
        end else begin
            tx_ovf_q <= tx_write && !fifo_in_ready;
        end
    end

    // Receive path: running length and bad-code history per packet
    always_comb begin
        len_d      = len_q;
        code_bad_d = code_bad_q;
        rx_d       = '0;
        seg_bytes  = '0;
        rx_bad     = 1'b0;
        for (int s = 0; s < SEG_NUM; s++) begin
            if (line_rx_word_i[s].ena) begin
                if (line_rx_word_i[s].sop) begin
                    len_d      = '0;
                    code_bad_d = 1'b0;
                end
                code_bad_d = code_bad_d || line_rx_code_bad_i[s];
                seg_bytes  = line_rx_word_i[s].eop ?
                             SEG_BYTES_W5 - {1'b0, line_rx_word_i[s].mty} :
                             SEG_BYTES_W5;
                len_d      = len_add(len_d, seg_bytes);
                rx_d[s]      = spb_seg_clean(line_rx_word_i[s]);
                rx_d[s].err  = 1'b0;
                if (line_rx_word_i[s].eop) begin
                    rx_bad = code_bad_d || line_rx_fcs_bad_i[s] ||
                             (len_d < MIN_FRAME_LEN) ||
                             (len_d > {1'b0, rx_max_frame_length_i});
                    rx_d[s].err = rx_bad;
                    if (rx_bad) begin
                        rx_d[s].mty[2:0] = MTY_ERR_LOW;
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_q       <= '0;
            len_q      <= '0;
            code_bad_q <= 1'b0;
        end else begin
            rx_q       <= rx_d;
            len_q      <= len_d;
            code_bad_q <= code_bad_d;
        end
    end

    // No receive back-pressure exists; the user side must take every word
    assign bus.rx_word = rx_q;
    assign bus.tx_rdy  = tx_rdy_q;
    assign bus.tx_ovf  = tx_ovf_q;
endmodule : spb_mac_end

// ### verilog/spb_user_end.sv
// User packet logic end of the segmented packet bus
`timescale 1ns/10ps
module spb_user_end
    import spb_pkg::*;
(
    // Clock and reset
    input  wire logic          sys_clk_i,
    input  wire logic          arst_n_i,
    // Packet bus toward the MAC
    spb_if.user                bus,
    // Transmit requests from the application
    input  wire logic          usr_tx_valid_i,
    input  wire spb_word_type  usr_tx_word_i,
    output logic               usr_tx_ready_o,
    output logic               usr_tx_drop_o,
    output logic               usr_tx_ovf_o,
    // Received words to the application
    output spb_word_type       usr_rx_word_o
);
    spb_word_type tx_q;
    spb_word_type tx_clean;
    logic         rdy_q;
    logic         drop_q;
    logic         ovf_q;
    logic         take;
    logic         legal;
    spb_word_type rx_q;

    always_comb begin
        for (int s = 0; s < SEG_NUM; s++) begin
            tx_clean[s] = spb_seg_clean(usr_tx_word_i[s]);
        end
    end

    assign legal = spb_layout_ok(usr_tx_word_i);
    // Ready is one cycle late; that single extra write is inside the allowance
    assign take  = usr_tx_valid_i && rdy_q;

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_q <= '0;
        end else if (take && legal) begin
            tx_q <= tx_clean;
        end else begin
            tx_q <= '0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdy_q  <= 1'b0;
            drop_q <= 1'b0;
            ovf_q  <= 1'b0;
        end else begin
            rdy_q  <= bus.tx_rdy;
            drop_q <= take && !legal;
            ovf_q  <= bus.tx_ovf;
        end
    end

    // Capture unconditionally: the receive side cannot be stalled
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_q <= '0;
        end else begin
            rx_q <= bus.rx_word;
        end
    end

    assign bus.tx_word    = tx_q;
    assign usr_tx_ready_o = rdy_q;
    assign usr_tx_drop_o  = drop_q;
    assign usr_tx_ovf_o   = ovf_q;
    assign usr_rx_word_o  = rx_q;
endmodule : spb_user_end

// ### tb/spb_bus_monitor.sv
// Concurrent checks on the segmented packet bus between the two ends
`timescale 1ns/10ps
module spb_bus_monitor
    import spb_pkg::*;
(
    // Clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         arst_n_i,
    // Bus signals
    input  wire spb_word_type tx_word,
    input  wire logic         tx_rdy,
    input  wire logic         tx_ovf,
    input  wire spb_word_type rx_word
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    wire logic tx_any = tx_word[0].ena | tx_word[1].ena | tx_word[2].ena | tx_word[3].ena;

    for (genvar s = 0; s < SEG_NUM; s++) begin : g_seg
        tx_idle_a: assert property (!tx_word[s].ena |-> tx_word[s] == '0)
            else $error("idle transmit segment not cleared");
        tx_ctl_a: assert property (tx_word[s].ena && !tx_word[s].eop |->
            !tx_word[s].err && tx_word[s].mty == 4'h0)
            else $error("transmit error or empty count off end");
        rx_idle_a: assert property (!rx_word[s].ena |-> rx_word[s] == '0)
            else $error("idle receive segment not cleared");
        rx_err_a: assert property (rx_word[s].ena && !rx_word[s].eop |-> !rx_word[s].err)
            else $error("receive error off end");
        rx_mty_a: assert property (rx_word[s].ena && rx_word[s].eop && rx_word[s].err |->
            rx_word[s].mty[2:0] == 3'h0)
            else $error("receive empty low bits set on error");
        if (s > 0) begin : g_gap
            tx_gap_a: assert property ((tx_word[s].ena |-> tx_word[s-1].ena) and
                (tx_word[s-1].ena && !tx_word[s-1].eop |-> tx_word[s].ena))
                else $error("gap in transmit segments");
        end
    end

    // Overflow only answers a write that found the buffer full
    ovf_cause_a: assert property (tx_ovf |-> $past(tx_any) && !tx_rdy)
        else $error("overflow without write or with ready");
    rdy_fall_a: assert property ($fell(tx_rdy) |-> $past(tx_any) || $past(tx_any, 2))
        else $error("ready fell without a write");

    cover property ($fell(tx_rdy));
    cover property (tx_word[3].ena && tx_word[3].eop);
    cover property (rx_word[0].ena && rx_word[0].eop && rx_word[0].err);
    cover property (rx_word[1].ena && rx_word[1].eop && !rx_word[1].err);
endmodule : spb_bus_monitor

// ### tb/segmented_packet_bus_tb.sv
// Testbench joining both ends of the segmented packet bus
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD t=%0t got %0h exp %0h", $time, (g), (e)); end end
module segmented_packet_bus_tb;
    import spb_pkg::*;
    logic         sys_clk_i = 1'b0;
    logic         arst_n_i = 1'b0;
    logic         usr_tx_valid_i = 1'b0;
    logic         line_tx_ready_i = 1'b0;
    logic         usr_tx_ready_o, usr_tx_drop_o, usr_tx_ovf_o, line_tx_valid_o;
    logic [3:0]   fcs_bad = 4'h0, code_bad = 4'h0;
    logic [14:0]  rx_max = 15'h0050;
    spb_word_type usr_tx_word_i = '0, line_rx_word_i = '0, usr_rx_word_o, line_tx_word_o;
    int           mismatches = 0, n_tests = 0;
    spb_if bus ();
    spb_if bus2 ();

    spb_user_end spb_user_end_i (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .bus(bus),
        .usr_tx_valid_i(usr_tx_valid_i), .usr_tx_word_i(usr_tx_word_i),
        .usr_tx_ready_o(usr_tx_ready_o), .usr_tx_drop_o(usr_tx_drop_o),
        .usr_tx_ovf_o(usr_tx_ovf_o), .usr_rx_word_o(usr_rx_word_o));
    spb_mac_end spb_mac_end_i (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .bus(bus),
        .line_tx_valid_o(line_tx_valid_o), .line_tx_word_o(line_tx_word_o),
        .line_tx_ready_i(line_tx_ready_i), .line_rx_word_i(line_rx_word_i),
        .line_rx_fcs_bad_i(fcs_bad), .line_rx_code_bad_i(code_bad),
        .rx_max_frame_length_i(rx_max));
    // Second MAC end faces a raw driver that ignores ready, with its line stalled
    spb_mac_end spb_mac_end_i2 (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .bus(bus2),
        .line_tx_valid_o(), .line_tx_word_o(), .line_tx_ready_i(1'b0),
        .line_rx_word_i('0), .line_rx_fcs_bad_i(4'h0), .line_rx_code_bad_i(4'h0),
        .rx_max_frame_length_i(rx_max));
    spb_bus_monitor spb_bus_monitor_i (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
        .tx_word(bus.tx_word), .tx_rdy(bus.tx_rdy), .tx_ovf(bus.tx_ovf), .rx_word(bus.rx_word));

    function automatic logic [SEG_W-1:0] pat(input int s);
        logic [SEG_W-1:0] d;
        for (int k = 0; k < SEG_BYTES; k++)
            d[SEG_W-1-8*k -: 8] = 8'(s * 16 + k);
        return d;
    endfunction : pat

    function automatic spb_word_type wrd(input int last, input int tag, input logic sop,
                                         input logic eop, input logic err, input logic [3:0] mty);
        spb_word_type w;
        w = '0;
        for (int s = 0; s <= last; s++) begin
            w[s].ena  = 1'b1;
            w[s].data = pat(tag + s);
        end
        w[0].sop    = sop;
        w[last].eop = eop;
        w[last].err = err;
        w[last].mty = mty;
        return w;
    endfunction : wrd

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic send(input spb_word_type w);
        int i;
        for (i = 0; i < 50 && usr_tx_ready_o !== 1'b1; i++)
            @(negedge sys_clk_i);
        if (i == 50) begin
            mismatches++;
            tally_and_finish();
        end
        usr_tx_valid_i = 1'b1;
        usr_tx_word_i  = w;
        @(negedge sys_clk_i);
        usr_tx_valid_i = 1'b0;
    endtask : send

    // Stalls one cycle before each accept so the buffer sees a slow drain
    task automatic pop(input spb_word_type e);
        int i;
        @(negedge sys_clk_i);
        for (i = 0; i < 50 && line_tx_valid_o !== 1'b1; i++)
            @(negedge sys_clk_i);
        if (i == 50) begin
            mismatches++;
            tally_and_finish();
        end
        `CHK(line_tx_word_o, e)
        line_tx_ready_i = 1'b1;
        @(negedge sys_clk_i);
        line_tx_ready_i = 1'b0;
    endtask : pop

    task automatic rx(input spb_word_type w1, w2, e1, e2, input logic [3:0] cb, fb);
        line_rx_word_i = w1;
        code_bad       = cb;
        @(negedge sys_clk_i);
        line_rx_word_i = w2;
        code_bad       = 4'h0;
        fcs_bad        = fb;
        `CHK(bus.rx_word, e1)
        @(negedge sys_clk_i);
        line_rx_word_i = '0;
        fcs_bad        = 4'h0;
        `CHK(bus.rx_word, e2)
        `CHK(usr_rx_word_o, e1)
        @(negedge sys_clk_i);
        `CHK(usr_rx_word_o, e2)
    endtask : rx

    task automatic t_reset();
        @(negedge sys_clk_i);
        `CHK(bus.tx_rdy, 1'b1)
        `CHK(line_tx_valid_o, 1'b0)
        @(negedge sys_clk_i);
        `CHK(usr_tx_ready_o, 1'b1)
        $display("test reset done");
    endtask : t_reset

    task automatic t_tx();
        spb_word_type w, e;
        w        = wrd(3, 0, 1'b1, 1'b1, 1'b0, 4'h5);
        e        = w;
        w[1].mty = 4'h3;
        w[1].err = 1'b1;
        send(w);
        `CHK(bus.tx_word, e)
        pop(e);
        w         = wrd(0, 4, 1'b1, 1'b1, 1'b1, 4'hF);
        w[1].data = pat(9);
        e         = w;
        e[1]      = '0;
        send(w);
        `CHK(bus.tx_word, e)
        e[0].data = ERR_WORD;
        e[0].mty  = 4'h8;
        pop(e);
        $display("test tx done");
    endtask : t_tx

    task automatic t_drop();
        spb_word_type w;
        w    = wrd(3, 0, 1'b1, 1'b1, 1'b0, 4'h0);
        w[0] = '0;
        send(w);
        `CHK(usr_tx_drop_o, 1'b1)
        repeat (3) @(negedge sys_clk_i);
        `CHK(line_tx_valid_o, 1'b0)
        $display("test drop done");
    endtask : t_drop

    task automatic t_fill();
        int n;
        // Valid stays up across the burst so it is never lowered and raised in one step
        usr_tx_valid_i = 1'b1;
        for (n = 0; n < 20 && usr_tx_ready_o === 1'b1; n++) begin
            usr_tx_word_i = wrd(0, n, 1'b1, 1'b1, 1'b0, 4'h0);
            @(negedge sys_clk_i);
        end
        usr_tx_valid_i = 1'b0;
        `CHK(bus.tx_rdy, 1'b0)
        `CHK(n >= 5 && n <= FIFO_DEPTH, 1'b1)
        for (int k = 0; k < n; k++)
            pop(wrd(0, k, 1'b1, 1'b1, 1'b0, 4'h0));
        `CHK(line_tx_valid_o, 1'b0)
        `CHK(usr_tx_ovf_o, 1'b0)
        $display("test fill done");
    endtask : t_fill

    task automatic t_ovf();
        int o;
        o = 0;
        for (int k = 0; k < FIFO_DEPTH + 3; k++) begin
            o += (bus2.tx_ovf === 1'b1);
            bus2.tx_word = (k <= FIFO_DEPTH) ? wrd(0, k, 1'b1, 1'b1, 1'b0, 4'h0) : '0;
            @(negedge sys_clk_i);
        end
        `CHK(o, 1)
        `CHK(bus2.tx_rdy, 1'b0)
        $display("test overflow done");
    endtask : t_ovf

    task automatic t_rx();
        rx(wrd(3, 0, 1, 1, 0, 0), '0, wrd(3, 0, 1, 1, 0, 0), '0, 4'h0, 4'h0);
        rx('0, wrd(3, 0, 1, 1, 0, 0), '0, wrd(3, 0, 1, 1, 1, 0), 4'h0, 4'h8);
        rx(wrd(0, 2, 1, 1, 0, 4'hD), '0, wrd(0, 2, 1, 1, 1, 4'h8), '0, 4'h0, 4'h0);
        rx(wrd(3, 0, 1, 0, 0, 0), wrd(0, 4, 0, 1, 0, 4'h3), wrd(3, 0, 1, 0, 0, 0),
           wrd(0, 4, 0, 1, 0, 4'h3), 4'h0, 4'h0);
        rx(wrd(3, 0, 1, 0, 0, 0), wrd(1, 4, 0, 1, 0, 0), wrd(3, 0, 1, 0, 0, 0),
           wrd(1, 4, 0, 1, 1, 0), 4'h0, 4'h0);
        rx(wrd(3, 0, 1, 0, 0, 0), wrd(0, 4, 0, 1, 0, 0), wrd(3, 0, 1, 0, 0, 0),
           wrd(0, 4, 0, 1, 1, 0), 4'h2, 4'h0);
        $display("test rx done");
    endtask : t_rx

    initial begin
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    initial begin
        bus2.tx_word = '0;
        repeat (20) @(negedge sys_clk_i);
        arst_n_i = 1'b1;
        t_reset();
        t_tx();
        t_drop();
        t_fill();
        t_ovf();
        t_rx();
        tally_and_finish();
    end
endmodule : segmented_packet_bus_tb
